// ### hw/ssq_pkg.sv
// Package of constants and types for the sample sequencer control block
package ssq_pkg;
	localparam int SSQ_NSEQ       = 4;
	localparam int SSQ_DW         = 12;
	localparam int SSQ_SUMW       = 18;
	localparam int SSQ_MAXSTEP    = 8;
	localparam logic [3:0] SSQ_DEPTH0 = 4'h8;
	localparam logic [3:0] SSQ_DEPTH1 = 4'h4;
	localparam logic [3:0] SSQ_DEPTH2 = 4'h4;
	localparam logic [3:0] SSQ_DEPTH3 = 4'h1;
	localparam logic [2:0] SSQ_INPUT_MAX = 3'h6;
	// Register byte addresses
	localparam logic [7:0] SSQ_A_ENABLE  = 8'h00;
	localparam logic [7:0] SSQ_A_AVG     = 8'h04;
	localparam logic [7:0] SSQ_A_RIS     = 8'h08;
	localparam logic [7:0] SSQ_A_IM      = 8'h0c;
	localparam logic [7:0] SSQ_A_MIS     = 8'h10;
	localparam logic [7:0] SSQ_A_PSTRIG  = 8'h14;
	localparam logic [7:0] SSQ_A_OVF     = 8'h18;
	localparam logic [7:0] SSQ_A_UNF     = 8'h1c;
	localparam logic [7:0] SSQ_A_TRIGSRC = 8'h20;
	localparam logic [7:0] SSQ_A_PRIO    = 8'h24;
	localparam logic [7:0] SSQ_A_STEP    = 8'h40;
	localparam logic [7:0] SSQ_A_FIFO    = 8'h80;
	localparam logic [7:0] SSQ_A_LEVEL   = 8'h90;
	// Step word: bits 2:0 input, 3 last, 4 irq
	localparam int SSQ_ST_LAST = 3;
	localparam int SSQ_ST_IRQ  = 4;
	localparam logic [3:0] SSQ_TRIG_PROC   = 4'h0;
	localparam logic [3:0] SSQ_TRIG_EXT    = 4'h1;
	localparam logic [3:0] SSQ_TRIG_TIMER  = 4'h2;
	localparam logic [3:0] SSQ_TRIG_PWM0   = 4'h3;
	localparam logic [3:0] SSQ_TRIG_PWM1   = 4'h4;
	localparam logic [3:0] SSQ_TRIG_PWM2   = 4'h5;
	localparam logic [3:0] SSQ_TRIG_ALWAYS = 4'hf;
	localparam logic [2:0] SSQ_AVG_MAXLOG  = 3'h6;
	localparam logic [1:0] SSQ_PRIO_RESET  = 2'h0;
	typedef enum logic [1:0] {SSQ_IDLE, SSQ_CONV, SSQ_WAIT} ssq_state_t;
endpackage

// ### hw/ssq_averager.sv
// Global hardware averager: accumulates 2^n raw conversions into one result
module ssq_averager
	import ssq_pkg::*;
(
	// Clock and reset
	input  wire logic                clk_in,
	input  wire logic                rst_in,
	// Setting
	input  wire logic [2:0]          averaging_factor_in,
	// Raw conversions
	input  wire logic                raw_valid_in,
	input  wire logic [SSQ_DW-1:0]   raw_data_in,
	input  wire logic                clear_in,
	// Averaged result
	output logic                     avg_valid_out,
	output logic [SSQ_DW-1:0]        avg_data_out
);
	logic [SSQ_SUMW-1:0] sum_reg;
	logic [6:0]          cnt_reg;
	logic [SSQ_SUMW-1:0] sum_add;
	logic [6:0]          target;
	logic                done;

	// Number of raw conversions per result; zero factor passes each one through
	assign target  = 7'(7'h01 << averaging_factor_in);
	assign sum_add = sum_reg + SSQ_SUMW'(raw_data_in);
	assign done    = raw_valid_in && ((cnt_reg + 7'h01) == target);

	// Accumulate raw conversions; the last one of a group restarts the sum
	always_ff @(posedge clk_in) begin
		if (rst_in || clear_in || done) begin
			sum_reg <= '0;
			cnt_reg <= '0;
		end else if (raw_valid_in) begin
			sum_reg <= sum_add;
			cnt_reg <= cnt_reg + 7'h01;
		end
	end

	// Result stands in the cycle of the last raw conversion, while the sequencer still waits
	assign avg_valid_out = done;
	assign avg_data_out  = SSQ_DW'(sum_add >> averaging_factor_in);
endmodule

// ### hw/ssq_top.sv
// Sample sequencer control: sequences, arbiter, result FIFOs, interrupts, Avalon-MM slave
module ssq_top
	import ssq_pkg::*;
(
	// Clock and reset
	input  wire logic              clk_in,
	input  wire logic              rst_in,
	// Avalon-MM slave
	input  wire logic [7:0]        avs_address_in,
	input  wire logic              avs_read_in,
	input  wire logic              avs_write_in,
	input  wire logic [31:0]       avs_writedata_in,
	output logic [31:0]            avs_readdata_out,
	output logic                   avs_waitrequest_out,
	// Trigger inputs
	input  wire logic              trig_ext_in,
	input  wire logic              trig_timer_in,
	input  wire logic [2:0]        trig_pwm_in,
	// Converter core
	output logic                   conv_start_out,
	output logic [2:0]             conv_input_out,
	input  wire logic              conv_done_in,
	input  wire logic [SSQ_DW-1:0] conv_data_in,
	// Interrupt
	output logic                   irq_out
);
	logic [3:0]  enable_reg, ris_reg, im_reg, ovf_reg, unf_reg, pend_reg;
	logic [2:0]  avg_reg;
	logic [15:0] trigsrc_reg;
	logic [7:0]  sequence_priority_reg;
	logic [4:0]  step_cfg [SSQ_NSEQ][SSQ_MAXSTEP];
	logic [SSQ_DW-1:0] fifo_mem [SSQ_NSEQ][SSQ_MAXSTEP];
	logic [2:0]  wp_reg [SSQ_NSEQ];
	logic [2:0]  rp_reg [SSQ_NSEQ];
	logic [3:0]  lvl_reg [SSQ_NSEQ];
	ssq_state_t  state_reg;
	logic [1:0]  cur_reg;
	logic [2:0]  step_reg;
	logic        ack_reg;
	logic [3:0]  src_trig, hw_trig, proc_trig, trig_any, push, pop, fifo_cap_hit;
	logic        wr, rd, avg_valid, grant_ok, step_done;
	logic [SSQ_DW-1:0] avg_data;
	logic [1:0]  grant;
	logic [4:0]  cur_step;
	logic [1:0]  aseq;
	logic [2:0]  astep;
	logic [1:0]  fseq;

	// Capacity of each sequence
	function automatic logic [3:0] depth_of(input logic [1:0] s);
		unique case (s)
			2'h0: depth_of = SSQ_DEPTH0;
			2'h1: depth_of = SSQ_DEPTH1;
			2'h2: depth_of = SSQ_DEPTH2;
			2'h3: depth_of = SSQ_DEPTH3;
		endcase
	endfunction

	// Select one trigger source for a sequence
	function automatic logic pick_src(input logic [3:0] code, input logic ext,
		input logic tmr, input logic [2:0] pwm);
		unique case (code)
			SSQ_TRIG_EXT:    pick_src = ext;
			SSQ_TRIG_TIMER:  pick_src = tmr;
			SSQ_TRIG_PWM0:   pick_src = pwm[0];
			SSQ_TRIG_PWM1:   pick_src = pwm[1];
			SSQ_TRIG_PWM2:   pick_src = pwm[2];
			SSQ_TRIG_ALWAYS: pick_src = 1'b1;
			default:         pick_src = 1'b0;
		endcase
	endfunction

	// Bus decode; one wait cycle then acknowledge
	assign wr    = avs_write_in && !ack_reg;
	assign rd    = avs_read_in && !ack_reg;
	assign aseq  = avs_address_in[4:3];
	assign astep = avs_address_in[2:0];
	assign fseq  = avs_address_in[3:2]; // FIFO words sit one word apart

	// Per-sequence trigger and FIFO decode
	genvar g;
	generate
		for (g = 0; g < SSQ_NSEQ; g++) begin : g_seq
			assign hw_trig[g]   = pick_src(trigsrc_reg[4*g +: 4], trig_ext_in,
				trig_timer_in, trig_pwm_in);
			assign proc_trig[g] = wr && (avs_address_in == SSQ_A_PSTRIG) && avs_writedata_in[g]
				&& (trigsrc_reg[4*g +: 4] == SSQ_TRIG_PROC);
			assign src_trig[g]  = enable_reg[g] && (hw_trig[g] || proc_trig[g]);
			assign pop[g]       = rd && (avs_address_in == (SSQ_A_FIFO + 8'(4*g)));
			assign fifo_cap_hit[g] = (lvl_reg[g] != 4'h0);
			assign push[g]      = step_done && (cur_reg == 2'(g))
				&& (lvl_reg[g] != depth_of(2'(g)));
		end
	endgenerate
	assign trig_any = pend_reg | src_trig;
	// A step completes when its averaged result arrives, even if the FIFO is full
	assign step_done = avg_valid && (state_reg == SSQ_WAIT);

	// Priority arbiter over pending sequences, 0 highest
	always_comb begin
		logic [1:0] best;
		best     = 2'h3;
		grant    = 2'h0;
		grant_ok = 1'b0;
		for (int i = 0; i < SSQ_NSEQ; i++) begin
			if (pend_reg[i] && (!grant_ok || sequence_priority_reg[2*i +: 2] < best)) begin
				best     = sequence_priority_reg[2*i +: 2];
				grant    = 2'(i);
				grant_ok = 1'b1;
			end
		end
	end

	assign cur_step = step_cfg[cur_reg][step_reg];

	// Hardware averager shared by all sequences
	ssq_averager u_avg (
		.clk_in              (clk_in),
		.rst_in              (rst_in),
		.averaging_factor_in (avg_reg),
		.raw_valid_in        (conv_done_in && state_reg == SSQ_WAIT),
		.raw_data_in         (conv_data_in),
		.clear_in            (state_reg == SSQ_IDLE),
		.avg_valid_out       (avg_valid),
		.avg_data_out        (avg_data)
	);

	// Sequencer: issue raw conversions of one step until the averaged result arrives
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_reg      <= SSQ_IDLE;
			cur_reg        <= '0;
			step_reg       <= '0;
			conv_start_out <= 1'b0;
			conv_input_out <= '0;
		end else begin
			conv_start_out <= 1'b0;
			unique case (state_reg)
				SSQ_IDLE: if (grant_ok) begin
					cur_reg   <= grant;
					step_reg  <= '0;
					state_reg <= SSQ_CONV;
				end
				SSQ_CONV: begin
					conv_start_out <= 1'b1;
					conv_input_out <= (cur_step[2:0] > SSQ_INPUT_MAX) ? SSQ_INPUT_MAX
						: cur_step[2:0];
					state_reg      <= SSQ_WAIT;
				end
				SSQ_WAIT: if (avg_valid) begin
					if (cur_step[SSQ_ST_LAST] || (4'(step_reg) + 4'h1 == depth_of(cur_reg)))
						state_reg <= SSQ_IDLE;
					else begin
						step_reg  <= step_reg + 3'h1;
						state_reg <= SSQ_CONV;
					end
				end else if (conv_done_in) begin
					state_reg <= SSQ_CONV;
				end
			endcase
		end
	end

	// Result FIFOs, one per sequence
	generate
		for (g = 0; g < SSQ_NSEQ; g++) begin : g_fifo
			always_ff @(posedge clk_in) begin
				if (rst_in) begin
					wp_reg[g]  <= '0;
					rp_reg[g]  <= '0;
					lvl_reg[g] <= '0;
				end else begin
					if (push[g]) begin
						fifo_mem[g][wp_reg[g]] <= avg_data;
						wp_reg[g] <= (4'(wp_reg[g]) + 4'h1 == depth_of(2'(g))) ? 3'h0
							: wp_reg[g] + 3'h1;
					end
					if (pop[g] && fifo_cap_hit[g])
						rp_reg[g] <= (4'(rp_reg[g]) + 4'h1 == depth_of(2'(g))) ? 3'h0
							: rp_reg[g] + 3'h1;
					lvl_reg[g] <= lvl_reg[g] + 4'(push[g]) - 4'(pop[g] && fifo_cap_hit[g]);
				end
			end
		end
	endgenerate

	// Flags: hardware set wins over software clear
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			pend_reg <= '0;
			ris_reg  <= '0;
			ovf_reg  <= '0;
			unf_reg  <= '0;
		end else begin
			for (int i = 0; i < SSQ_NSEQ; i++) begin
				if (state_reg == SSQ_IDLE && grant_ok && grant == 2'(i))
					pend_reg[i] <= src_trig[i];
				else if (src_trig[i])
					pend_reg[i] <= 1'b1;
				if (src_trig[i] && fifo_cap_hit[i])
					ovf_reg[i] <= 1'b1;
				else if (wr && avs_address_in == SSQ_A_OVF && avs_writedata_in[i])
					ovf_reg[i] <= 1'b0;
				if (pop[i] && !fifo_cap_hit[i])
					unf_reg[i] <= 1'b1;
				else if (wr && avs_address_in == SSQ_A_UNF && avs_writedata_in[i])
					unf_reg[i] <= 1'b0;
				if (step_done && cur_reg == 2'(i) && cur_step[SSQ_ST_IRQ])
					ris_reg[i] <= 1'b1;
				else if (wr && avs_address_in == SSQ_A_RIS && avs_writedata_in[i])
					ris_reg[i] <= 1'b0;
			end
		end
	end

	// Configuration registers
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			enable_reg            <= '0;
			avg_reg               <= '0;
			im_reg                <= '0;
			trigsrc_reg           <= '0;
			sequence_priority_reg <= {4{SSQ_PRIO_RESET}};
		end else if (wr) begin
			if (avs_address_in == SSQ_A_ENABLE)
				enable_reg <= avs_writedata_in[3:0];
			if (avs_address_in == SSQ_A_AVG)
				avg_reg <= (avs_writedata_in[2:0] > SSQ_AVG_MAXLOG) ? SSQ_AVG_MAXLOG
					: avs_writedata_in[2:0];
			if (avs_address_in == SSQ_A_IM)
				im_reg <= avs_writedata_in[3:0];
			if (avs_address_in == SSQ_A_TRIGSRC)
				trigsrc_reg <= avs_writedata_in[15:0];
			if (avs_address_in == SSQ_A_PRIO)
				sequence_priority_reg <= avs_writedata_in[7:0];
		end
	end

	// Step configuration table
	always_ff @(posedge clk_in) begin
		if (wr && avs_address_in[7:5] == SSQ_A_STEP[7:5] && 4'(astep) < depth_of(aseq))
			step_cfg[aseq][astep] <= avs_writedata_in[4:0];
	end

	// Read mux, handshake and interrupt output
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ack_reg             <= 1'b0;
			avs_waitrequest_out <= 1'b1;
			avs_readdata_out    <= '0;
			irq_out             <= 1'b0;
		end else begin
			ack_reg             <= (avs_read_in || avs_write_in) && !ack_reg;
			avs_waitrequest_out <= !((avs_read_in || avs_write_in) && !ack_reg);
			irq_out             <= |(ris_reg & im_reg);
			if (rd) begin
				avs_readdata_out <= '0;
				unique case (avs_address_in)
					SSQ_A_ENABLE:  avs_readdata_out <= {28'h0, enable_reg};
					SSQ_A_AVG:     avs_readdata_out <= {29'h0, avg_reg};
					SSQ_A_RIS:     avs_readdata_out <= {28'h0, ris_reg};
					SSQ_A_IM:      avs_readdata_out <= {28'h0, im_reg};
					SSQ_A_MIS:     avs_readdata_out <= {28'h0, ris_reg & im_reg};
					SSQ_A_OVF:     avs_readdata_out <= {28'h0, ovf_reg};
					SSQ_A_UNF:     avs_readdata_out <= {28'h0, unf_reg};
					SSQ_A_TRIGSRC: avs_readdata_out <= {16'h0, trigsrc_reg};
					SSQ_A_PRIO:    avs_readdata_out <= {24'h0, sequence_priority_reg};
					default: begin
						if (avs_address_in[7:5] == SSQ_A_STEP[7:5])
							avs_readdata_out <= {27'h0, step_cfg[aseq][astep]};
						else if (avs_address_in[7:4] == SSQ_A_FIFO[7:4] && fifo_cap_hit[fseq])
							avs_readdata_out <= {20'h0, fifo_mem[fseq][rp_reg[fseq]]};
						else if (avs_address_in[7:4] == SSQ_A_LEVEL[7:4])
							avs_readdata_out <= {28'h0, lvl_reg[aseq]};
					end
				endcase
			end
		end
	end
endmodule

// ### testbench/ssq_top_chk.sv
// Port-level assertions for the sequencer top, bound into it
module ssq_top_chk
	import ssq_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// Register bus
	input  wire logic [7:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [31:0] avs_readdata_out,
	input  wire logic        avs_waitrequest_out,
	// Converter and interrupt
	input  wire logic        conv_start_out,
	input  wire logic [2:0]  conv_input_out,
	input  wire logic        irq_out
);
	logic [3:0] mask_reg;

	// Shadow of the interrupt mask, taken on the accepting edge
	always_ff @(posedge clk_in) begin
		if (rst_in)
			mask_reg <= 4'h0;
		else if (avs_write_in && avs_waitrequest_out && avs_address_in == SSQ_A_IM)
			mask_reg <= avs_writedata_in[3:0];
	end

	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);

	property p_ack_pulse;
		!avs_waitrequest_out |=> avs_waitrequest_out;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("waitrequest low too long");
	property p_answer;
		(avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out;
	endproperty
	a_answer: assert property (p_answer) else $error("access not answered");
	property p_cause;
		!avs_waitrequest_out |-> $past(avs_read_in || avs_write_in);
	endproperty
	a_cause: assert property (p_cause) else $error("answer without request");
	property p_unmapped;
		avs_read_in && avs_waitrequest_out && avs_address_in >= 8'ha0 |=> avs_readdata_out == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_hold;
		!(avs_read_in && avs_waitrequest_out) |=> $stable(avs_readdata_out);
	endproperty
	a_hold: assert property (p_hold) else $error("read data changed");
	property p_reset;
		$fell(rst_in) |-> avs_waitrequest_out && avs_readdata_out == 32'h0 && !irq_out;
	endproperty
	a_reset: assert property (p_reset) else $error("bad state after reset");
	property p_mask;
		irq_out |-> $past(mask_reg) != 4'h0;
	endproperty
	a_mask: assert property (p_mask) else $error("interrupt while all masked");
	property p_input;
		conv_start_out |-> conv_input_out <= SSQ_INPUT_MAX;
	endproperty
	a_input: assert property (p_input) else $error("input select out of range");
endmodule

bind ssq_top ssq_top_chk u_chk (.clk_in, .rst_in, .avs_address_in, .avs_read_in,
	.avs_write_in, .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out,
	.conv_start_out, .conv_input_out, .irq_out);

// ### testbench/adc_sample_sequencer_control_bench.sv
// Self-checking bench for the sample sequencer control block
module adc_sample_sequencer_control_bench
	import ssq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_in, rst_in, avs_read_in, avs_write_in, conv_done_in;
	logic        avs_waitrequest_out, conv_start_out, irq_out, tog, alt;
	logic [7:0]  avs_address_in;
	logic [31:0] avs_writedata_in, avs_readdata_out, q;
	logic [2:0]  conv_input_out, cur_in, dly;
	logic [2:0]  log_q[$];
	logic [11:0] conv_data_in;
	logic [4:0]  trg;
	int          miscompares, n_tests, n_starts;

	ssq_top uut (.clk_in, .rst_in, .avs_address_in, .avs_read_in, .avs_write_in,
		.avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .trig_ext_in(trg[0]),
		.trig_timer_in(trg[1]), .trig_pwm_in(trg[4:2]), .conv_start_out, .conv_input_out,
		.conv_done_in, .conv_data_in, .irq_out);

	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	// Converter stand-in: answers three cycles after a start, data line churns otherwise
	always @(posedge clk_in) begin
		conv_done_in <= 1'b0;
		conv_data_in <= ~conv_data_in;
		if (dly == 3'h1) begin
			conv_done_in <= 1'b1;
			conv_data_in <= 12'h100 + {5'h0, cur_in, 4'h0} + ((alt && tog) ? 12'h2 : 12'h0);
			tog <= ~tog;
		end
		if (dly != 3'h0)
			dly <= dly - 3'h1;
		if (conv_start_out === 1'b1) begin
			dly <= 3'h3;
			cur_in <= conv_input_out;
			log_q.push_back(conv_input_out);
			n_starts++;
		end
	end

	// One bus access, held until waitrequest is seen low
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		i = 0;
		@(posedge clk_in);
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_write_in <= w;
		avs_read_in <= ~w;
		@(posedge clk_in);
		while (avs_waitrequest_out !== 1'b0 && i < 20) begin
			i++;
			@(posedge clk_in);
		end
		if (i == 20)
			miscompares++;
		q = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		acc(1'b0, a, 32'h0);
		chk(q, exp);
	endtask

	// Waits a bounded time for the interrupt line
	task automatic wirq();
		int i;
		i = 0;
		while (irq_out !== 1'b1 && i < 2000) begin
			i++;
			@(posedge clk_in);
		end
		chk({31'h0, irq_out}, 32'h1);
	endtask

	// Masked and raw status, clear, processor trigger gating, empty pop
	task automatic t_irq();
		int s;
		rc(SSQ_A_RIS, 32'h0);
		acc(1'b1, SSQ_A_RIS, 32'hf);
		acc(1'b1, SSQ_A_ENABLE, 32'hf);
		acc(1'b1, SSQ_A_TRIGSRC, 32'h1000);
		s = n_starts;
		acc(1'b1, SSQ_A_PSTRIG, 32'h8);
		repeat (20) @(posedge clk_in);
		chk(n_starts - s, 32'h0);
		acc(1'b1, SSQ_A_TRIGSRC, 32'h0);
		acc(1'b1, SSQ_A_PSTRIG, 32'h8);
		repeat (20) @(posedge clk_in);
		chk({31'h0, irq_out}, 32'h0);
		chk(n_starts - s, 32'h1);
		rc(SSQ_A_RIS, 32'h8);
		rc(SSQ_A_MIS, 32'h0);
		acc(1'b1, SSQ_A_IM, 32'h8);
		wirq();
		rc(SSQ_A_MIS, 32'h8);
		rc(SSQ_A_FIFO + 8'hc, 32'h150);
		acc(1'b1, SSQ_A_RIS, 32'h8);
		rc(SSQ_A_RIS, 32'h0);
		chk({31'h0, irq_out}, 32'h0);
		rc(SSQ_A_FIFO + 8'hc, 32'h0);
		rc(SSQ_A_UNF, 32'h8);
		acc(1'b1, 8'hc0, 32'hff);
		rc(8'hc0, 32'h0);
	endtask

	// Averaging factors 1 to 6: conversions per result and the averaged value
	task automatic t_avg();
		int s;
		alt = 1'b1;
		for (int n = 1; n <= 6; n++) begin
			acc(1'b1, SSQ_A_AVG, n);
			s = n_starts;
			tog = 1'b0;
			acc(1'b1, SSQ_A_PSTRIG, 32'h8);
			wirq();
			chk(n_starts - s, 32'h1 << n);
			rc(SSQ_A_FIFO + 8'hc, 32'h151);
			acc(1'b1, SSQ_A_RIS, 32'h8);
		end
	endtask

	// Two sequences at once under 2x: priority, step order, end marker, FIFO order
	task automatic t_prio();
		logic [2:0] e[8] = '{3'h4, 3'h4, 3'h1, 3'h1, 3'h3, 3'h3, 3'h0, 3'h0};
		acc(1'b1, SSQ_A_PRIO, 32'he1);
		acc(1'b1, SSQ_A_AVG, 32'h1);
		acc(1'b1, SSQ_A_IM, 32'h1);
		tog = 1'b0;
		log_q.delete();
		acc(1'b1, SSQ_A_PSTRIG, 32'h3);
		wirq();
		repeat (20) @(posedge clk_in);
		chk(log_q.size(), 32'h8);
		foreach (e[i]) chk(log_q[i], e[i]);
		rc(SSQ_A_FIFO, 32'h111);
		rc(SSQ_A_FIFO, 32'h131);
		rc(SSQ_A_FIFO, 32'h101);
		rc(SSQ_A_FIFO + 8'h4, 32'h141);
		acc(1'b1, SSQ_A_RIS, 32'hf);
		acc(1'b1, SSQ_A_AVG, 32'h0);
		alt = 1'b0;
	endtask

	// Second trigger before the result was read
	task automatic t_ovf();
		acc(1'b1, SSQ_A_IM, 32'h8);
		for (int k = 0; k < 2; k++) begin
			acc(1'b1, SSQ_A_PSTRIG, 32'h8);
			wirq();
			acc(1'b1, SSQ_A_RIS, 32'h8);
		end
		rc(SSQ_A_OVF, 32'h8);
		acc(1'b1, SSQ_A_OVF, 32'h8);
		rc(SSQ_A_OVF, 32'h0);
		rc(SSQ_A_FIFO + 8'hc, 32'h150);
	endtask

	// Pin, timer and generator sources, then the free-running source
	task automatic t_src();
		int s;
		for (int k = 1; k <= 5; k++) begin
			acc(1'b1, SSQ_A_TRIGSRC, 32'(k) << 12);
			@(posedge clk_in);
			trg <= 5'h1 << (k - 1);
			@(posedge clk_in);
			trg <= 5'h0;
			wirq();
			rc(SSQ_A_FIFO + 8'hc, 32'h150);
			acc(1'b1, SSQ_A_RIS, 32'h8);
		end
		s = n_starts;
		acc(1'b1, SSQ_A_TRIGSRC, 32'hf000);
		repeat (60) @(posedge clk_in);
		chk(32'(n_starts - s >= 4), 32'h1);
		acc(1'b1, SSQ_A_ENABLE, 32'h0);
	endtask

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge clk_in);
		miscompares++;
		end_sim();
	end

	// Reset, step table, then the scenarios
	initial begin
		{rst_in, avs_read_in, avs_write_in, conv_done_in, tog, alt} = 6'h20;
		{avs_address_in, avs_writedata_in, conv_data_in, trg, dly, cur_in} = '0;
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		acc(1'b1, 8'h40, 32'h1);
		acc(1'b1, 8'h41, 32'h3);
		acc(1'b1, 8'h42, 32'h18);
		acc(1'b1, 8'h43, 32'h6);
		acc(1'b1, 8'h48, 32'h1c);
		acc(1'b1, 8'h58, 32'h1d);
		t_irq();
		t_avg();
		t_prio();
		t_ovf();
		t_src();
		end_sim();
	end
endmodule
